// ### logic/brs_pkg.sv
// Package: register map, field positions, reset values and servo timing for the reference servo block
`default_nettype none
package brs_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFF_ENABLE_LOAD = 4'h5;
   localparam logic [ADDR_W-1:0] OFF_SERVO_CFG = 4'h9;
   localparam logic [ADDR_W-1:0] OFF_VOLT_UPPER = 4'ha;
   localparam logic [ADDR_W-1:0] OFF_VOLT_LOW = 4'hb;
   localparam logic [ADDR_W-1:0] OFF_CUR_TARGET = 4'hc;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hd;
   localparam int unsigned VW = 11;
   localparam int unsigned CW = 8;
   localparam int unsigned BIT_SW_ENABLE = 0;
   localparam int unsigned BIT_LOAD = 1;
   localparam int unsigned BIT_DISCHARGE = 4;
   localparam int unsigned DIV_LSB = 6;
   localparam logic [VW-1:0] VOLT_CLAMP = 11'h780;
   localparam logic [7:0] RST_ENABLE_LOAD = 8'h00;
   localparam logic [7:0] RST_SERVO_CFG = 8'h00;
   localparam logic [7:0] RST_VOLT_UPPER = 8'h00;
   localparam logic [7:0] RST_VOLT_LOW = 8'h00;
   localparam logic [7:0] RST_CUR_TARGET = 8'h00;
   // Servo master clock rate and the four divide ratios selectable in the config field
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned SERVO_MASTER_HZ = 1000000;
   localparam int unsigned MASTER_CYCLES = CLK_HZ / SERVO_MASTER_HZ;
   localparam int unsigned DIV_RATIO0 = 1;
   localparam int unsigned DIV_RATIO1 = 2;
   localparam int unsigned DIV_RATIO2 = 4;
   localparam int unsigned DIV_RATIO3 = 8;
   typedef struct packed {
      logic enable;
      logic discharge;
   } brs_power_s;
endpackage : brs_pkg
`default_nettype wire

// ### logic/brs_servo_chan.sv
// One servo channel: comparator plus up/down counter stepping toward a target
`default_nettype none
module brs_servo_chan #(
   parameter int unsigned W = 8
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic hold_zero_i,
   input wire logic tick_i,
   input wire logic [W-1:0] target_i,
   output logic [W-1:0] count_o,
   output logic at_target_o
);
   wire logic go_up = count_o < target_i;
   wire logic go_down = count_o > target_i;

   always_ff @(posedge clk_i) begin
      if (!rstn_i || hold_zero_i) begin
         count_o <= '0;
      end else if (tick_i && go_up) begin
         count_o <= count_o + W'(1); // R10 R14
      end else if (tick_i && go_down) begin
         count_o <= count_o - W'(1); // R10 R14
      end
   end

   assign at_target_o = !go_up && !go_down;

   step_size_a: assert property (@(posedge clk_i) disable iff (!rstn_i || hold_zero_i)
      $past(rstn_i) && !$past(hold_zero_i) && count_o != $past(count_o) |->
      (count_o == $past(count_o) + W'(1)) || (count_o == $past(count_o) - W'(1)))
      else $error("servo count moved by more than one step"); // R14
   idle_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i || hold_zero_i)
      !tick_i |=> $stable(count_o))
      else $error("servo count moved without a tick"); // R10
endmodule : brs_servo_chan
`default_nettype wire

// ### logic/brs_top.sv
// Reference servo and enable control for a buck regulator, registers on Avalon-MM
// Behaviour
// R1 - Voltage target is 11 bits: an 8-bit register and a 3-bit register.
// R2 - Upper byte forms bits 10:3, the low field forms bits 2:0.
// R3 - Host writes both target fields before setting the load bit.
// R4 - Writing one to the load bit transfers all 11 bits at once.
// R5 - Active voltage target changes only on a load command.
// R6 - Load bit is a one-shot: one transfer per write, reads back zero.
// R7 - Voltage codes above 0x780 are clamped to 0x780.
// R8 - Current target is a full 8-bit register.
// R9 - Servo has 11-bit and 8-bit comparators and up/down counters.
// R10 - Counters step toward target each divided tick, hold when equal.
// R11 - Counter values, not registers, drive the reference converters.
// R12 - Voltage and current channels servo independently and in parallel.
// R13 - Two-bit config field picks servo clock divide ratio.
// R14 - Each tick moves a counter by exactly one step.
// R15 - Internal enable is enable pin OR register enable bit.
// R16 - Internal enable low holds voltage counter at zero; rising starts soft-start.
// R17 - Regulator disabled when internal enable low, regulates when high.
// R18 - Disabled with discharge bit set turns on discharge path.
// R19 - Open enable pin reads high so regulator enables at bias ready.
// R20 - External driver holds enable pin low for the minimum low time.
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`default_nettype none
module brs_top
   import brs_pkg::*;
#(
   parameter int unsigned MASTER_DIV = brs_pkg::MASTER_CYCLES
) (
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic [brs_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   input wire logic ENABLE_PIN_I,
   input wire logic BIAS_READY_I,
   output logic [brs_pkg::VW-1:0] VOLTAGE_REFERENCE_OUTPUT_O,
   output logic [brs_pkg::CW-1:0] CURRENT_REFERENCE_CONVERTER_O,
   output logic REGULATOR_ENABLE_O,
   output logic OUTPUT_DISCHARGE_PATH_O,
   output logic INTERNAL_ENABLE_O
);
   import brs_pkg::*;

   logic [7:0] voltage_target_upper_byte;
   logic [2:0] voltage_target_low_bits;
   logic [7:0] enable_and_load_control;
   logic [7:0] current_limit_target;
   logic [7:0] servo_and_discharge_config;
   logic [VW-1:0] active_voltage_target;
   logic ack;
   logic [15:0] master_cnt;
   logic master_tick;
   logic [3:0] div_cnt;
   logic servo_tick;
   brs_power_s power;

   wire logic [VW-1:0] v_count;
   wire logic [CW-1:0] c_count;
   wire logic v_at;
   wire logic c_at;

   // A request is answered one cycle after it is raised, then waitrequest drops for one edge
   wire logic req = (AVS_READ_I || AVS_WRITE_I) && !ack;
   wire logic wr_go = AVS_WRITE_I && ack;
   wire logic lane0 = AVS_BYTEENABLE_I[0];
   wire logic wr_en_load = wr_go && lane0 && AVS_ADDRESS_I == OFF_ENABLE_LOAD;
   wire logic wr_cfg = wr_go && lane0 && AVS_ADDRESS_I == OFF_SERVO_CFG;
   wire logic wr_vup = wr_go && lane0 && AVS_ADDRESS_I == OFF_VOLT_UPPER;
   wire logic wr_vlo = wr_go && lane0 && AVS_ADDRESS_I == OFF_VOLT_LOW;
   wire logic wr_cur = wr_go && lane0 && AVS_ADDRESS_I == OFF_CUR_TARGET;
   wire logic load_cmd = wr_en_load && AVS_WRITEDATA_I[BIT_LOAD]; // R4 R6
   wire logic [VW-1:0] raw_code = {voltage_target_upper_byte, voltage_target_low_bits}; // R1 R2
   wire logic [VW-1:0] clamped_code = (raw_code > VOLT_CLAMP) ? VOLT_CLAMP : raw_code; // R7
   wire logic next_internal_enable = ENABLE_PIN_I || enable_and_load_control[BIT_SW_ENABLE]; // R15 R19
   wire logic [1:0] div_sel = servo_and_discharge_config[DIV_LSB +: 2];

   function automatic logic [3:0] div_ratio(input logic [1:0] sel);
      case (sel)
         2'd0: div_ratio = 4'(DIV_RATIO0);
         2'd1: div_ratio = 4'(DIV_RATIO1);
         2'd2: div_ratio = 4'(DIV_RATIO2);
         default: div_ratio = 4'(DIV_RATIO3);
      endcase
   endfunction

   function automatic logic [7:0] reg_value(input logic [ADDR_W-1:0] a, input logic [7:0] el, input logic [7:0] cfg,
                                            input logic [7:0] vu, input logic [2:0] vl, input logic [7:0] cu,
                                            input logic [7:0] st);
      case (a)
         OFF_ENABLE_LOAD: reg_value = el;
         OFF_SERVO_CFG: reg_value = cfg;
         OFF_VOLT_UPPER: reg_value = vu;
         OFF_VOLT_LOW: reg_value = {5'h00, vl};
         OFF_CUR_TARGET: reg_value = cu;
         OFF_STATUS: reg_value = st;
         default: reg_value = 8'h00;
      endcase
   endfunction

   wire logic [7:0] status_byte = {5'h00, c_at, v_at, power.enable};
   wire logic [7:0] rd_byte = reg_value(AVS_ADDRESS_I, enable_and_load_control, servo_and_discharge_config,
                                        voltage_target_upper_byte, voltage_target_low_bits,
                                        current_limit_target, status_byte);

   // Bus handshake and read data
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         ack <= 1'b0;
         AVS_WAITREQUEST_O <= 1'b1;
         AVS_READDATA_O <= 32'h0000_0000;
      end else begin
         ack <= req;
         AVS_WAITREQUEST_O <= !req;
         if (req && AVS_READ_I) begin
            AVS_READDATA_O <= {24'h00_0000, rd_byte};
         end
      end
   end

   // Register writes; the load bit never stores, so it reads back zero
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         enable_and_load_control <= RST_ENABLE_LOAD;
         servo_and_discharge_config <= RST_SERVO_CFG;
         voltage_target_upper_byte <= RST_VOLT_UPPER;
         voltage_target_low_bits <= RST_VOLT_LOW[2:0];
         current_limit_target <= RST_CUR_TARGET;
      end else begin
         if (wr_en_load) begin
            enable_and_load_control <= AVS_WRITEDATA_I[7:0] & ~(8'h01 << BIT_LOAD); // R6
         end
         if (wr_cfg) begin
            servo_and_discharge_config <= AVS_WRITEDATA_I[7:0]; // R13
         end
         if (wr_vup) begin
            voltage_target_upper_byte <= AVS_WRITEDATA_I[7:0]; // R1
         end
         if (wr_vlo) begin
            voltage_target_low_bits <= AVS_WRITEDATA_I[2:0]; // R1
         end
         if (wr_cur) begin
            current_limit_target <= AVS_WRITEDATA_I[7:0]; // R8
         end
      end
   end

   // The host must write both fields before loading; the transfer takes whatever is stored then
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         active_voltage_target <= '0;
      end else if (load_cmd) begin
         active_voltage_target <= clamped_code; // R3 R4 R5 R7
      end
   end

   // Servo master clock enable, then the selectable divider
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         master_cnt <= '0;
         master_tick <= 1'b0;
         div_cnt <= '0;
         servo_tick <= 1'b0;
      end else begin
         master_tick <= master_cnt == 16'(MASTER_DIV - 1);
         master_cnt <= (master_cnt == 16'(MASTER_DIV - 1)) ? 16'h0000 : master_cnt + 16'h0001;
         servo_tick <= 1'b0;
         if (master_tick) begin
            if (div_cnt >= div_ratio(div_sel) - 4'h1) begin
               div_cnt <= 4'h0;
               servo_tick <= 1'b1; // R13
            end else begin
               div_cnt <= div_cnt + 4'h1;
            end
         end
      end
   end

   // Enable pin is sampled each clock; lows shorter than a cycle can be missed
   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         power <= '0;
      end else begin
         power.enable <= next_internal_enable && BIAS_READY_I; // R15 R17 R19 R20
         power.discharge <= !(next_internal_enable && BIAS_READY_I)
                            && servo_and_discharge_config[BIT_DISCHARGE]; // R18
      end
   end

   // Separate channels with their own comparators so ramps run in parallel
   brs_servo_chan #(.W(VW)) u_volt (
      .clk_i(CLK_I),
      .rstn_i(RSTN_I),
      .hold_zero_i(!power.enable), // R16
      .tick_i(servo_tick),
      .target_i(active_voltage_target),
      .count_o(v_count),
      .at_target_o(v_at)
   ); // R9 R12

   brs_servo_chan #(.W(CW)) u_cur (
      .clk_i(CLK_I),
      .rstn_i(RSTN_I),
      .hold_zero_i(1'b0),
      .tick_i(servo_tick),
      .target_i(current_limit_target),
      .count_o(c_count),
      .at_target_o(c_at)
   ); // R9 R12

   always_ff @(posedge CLK_I) begin
      if (!RSTN_I) begin
         VOLTAGE_REFERENCE_OUTPUT_O <= '0;
         CURRENT_REFERENCE_CONVERTER_O <= '0;
         REGULATOR_ENABLE_O <= 1'b0;
         OUTPUT_DISCHARGE_PATH_O <= 1'b0;
         INTERNAL_ENABLE_O <= 1'b0;
      end else begin
         VOLTAGE_REFERENCE_OUTPUT_O <= v_count; // R11
         CURRENT_REFERENCE_CONVERTER_O <= c_count; // R11
         REGULATOR_ENABLE_O <= power.enable; // R17
         OUTPUT_DISCHARGE_PATH_O <= power.discharge; // R18
         INTERNAL_ENABLE_O <= power.enable;
      end
   end

   load_only_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      !load_cmd |=> $stable(active_voltage_target))
      else $error("active target changed without a load"); // R5
   load_xfer_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      load_cmd |=> active_voltage_target == $past(clamped_code))
      else $error("load did not transfer the full code"); // R4
   clamp_limit_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      active_voltage_target <= VOLT_CLAMP)
      else $error("voltage target above clamp"); // R7
   load_readback_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      !enable_and_load_control[BIT_LOAD])
      else $error("load bit stored"); // R6
   enable_or_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      BIAS_READY_I && (ENABLE_PIN_I || enable_and_load_control[BIT_SW_ENABLE]) |=> ##1 REGULATOR_ENABLE_O)
      else $error("enable not followed"); // R15
   soft_start_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      !power.enable |=> v_count == '0)
      else $error("voltage counter not held at zero"); // R16
   discharge_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      OUTPUT_DISCHARGE_PATH_O |-> !REGULATOR_ENABLE_O)
      else $error("discharge while enabled"); // R18
   ref_follow_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      $past(RSTN_I) |-> CURRENT_REFERENCE_CONVERTER_O == $past(c_count))
      else $error("current reference not from counter"); // R11

   // Bus side: waitrequest is a single-cycle answer, idle keeps it high
   wait_pulse_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
      else $error("waitrequest low for more than one cycle");
   idle_wait_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      !AVS_READ_I && !AVS_WRITE_I |=> AVS_WAITREQUEST_O)
      else $error("waitrequest dropped with no request");
   read_upper_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      AVS_READDATA_O[31:8] == 24'h00_0000)
      else $error("read data upper lanes not zero");

   // Loading: one transfer per write, the clamp applied, both fields taken together
   one_shot_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R6
      load_cmd |=> !load_cmd)
      else $error("load command lasted more than one cycle");
   clamp_load_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R7
      load_cmd && raw_code > VOLT_CLAMP |=> active_voltage_target == VOLT_CLAMP)
      else $error("large code not clamped on load");
   code_load_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R2 R4
      load_cmd && raw_code <= VOLT_CLAMP |=>
      active_voltage_target == {$past(voltage_target_upper_byte), $past(voltage_target_low_bits)})
      else $error("loaded code not upper byte over low bits");

   // Servo: ticks come from the master enable; each channel moves or holds on its own
   tick_src_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R13
      servo_tick |-> $past(master_tick))
      else $error("servo tick without master tick");
   cur_move_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R10 R12
      servo_tick && !c_at |=> c_count != $past(c_count))
      else $error("current counter missed a tick");
   volt_move_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R10 R12
      servo_tick && !v_at && power.enable |=> v_count != $past(v_count))
      else $error("voltage counter missed a tick");
   cur_hold_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R10
      c_at |=> c_count == $past(c_count))
      else $error("current counter moved at target");
   volt_hold_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R10
      v_at && power.enable |=> v_count == $past(v_count))
      else $error("voltage counter moved at target");
   volt_follow_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R11
      $past(RSTN_I) |-> VOLTAGE_REFERENCE_OUTPUT_O == $past(v_count))
      else $error("voltage reference not from counter");

   // Power: enable and discharge outputs follow the internal enable two cycles later
   off_disable_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R17
      !power.enable |=> !REGULATOR_ENABLE_O && !INTERNAL_ENABLE_O)
      else $error("regulator on while internal enable low");
   enable_drop_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R15 R17
      !BIAS_READY_I || !(ENABLE_PIN_I || enable_and_load_control[BIT_SW_ENABLE]) |=> ##1 !REGULATOR_ENABLE_O)
      else $error("regulator stayed on after enable dropped");
   discharge_on_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R18
      !(next_internal_enable && BIAS_READY_I) && servo_and_discharge_config[BIT_DISCHARGE] |=> ##1
      OUTPUT_DISCHARGE_PATH_O)
      else $error("discharge path off while disabled");
   hiz_off_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I) // R18
      !servo_and_discharge_config[BIT_DISCHARGE] |=> ##1 !OUTPUT_DISCHARGE_PATH_O)
      else $error("discharge path on with discharge deselected");
endmodule : brs_top
`default_nettype wire

// ### testbench/brs_host_model.sv
// Host-side model: register traffic over the Avalon-MM slave port
`default_nettype none
module brs_host_model
   import brs_pkg::*;
(
   input wire logic clk_i,
   input wire logic waitrequest_i,
   input wire logic [31:0] readdata_i,
   output logic [3:0] address_o,
   output logic read_o,
   output logic write_o,
   output logic [31:0] writedata_o,
   output logic [3:0] byteenable_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      address_o = 4'h0;
      read_o = 1'b0;
      write_o = 1'b0;
      writedata_o = 32'h0;
      byteenable_o = 4'hf;
   end
   // No limit here: a slave that never answers is cut off by the bench's cycle ceiling
   task automatic xfer(input logic is_wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_i);
      address_o <= a;
      writedata_o <= {24'h0, d};
      read_o <= !is_wr;
      write_o <= is_wr;
      @(posedge clk_i);
      while (waitrequest_i !== 1'b0) @(posedge clk_i);
      q = readdata_i[7:0];
      read_o <= 1'b0;
      write_o <= 1'b0;
      // Stale data must not look valid once released
      writedata_o <= ~writedata_o;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] q);
      xfer(1'b0, a, 8'h00, q);
   endtask
   // Both halves first, the load command last
   task automatic set_volt(input logic [7:0] up, input logic [2:0] lo, input logic [7:0] ctrl);
      wr(OFF_VOLT_UPPER, up);
      wr(OFF_VOLT_LOW, {5'h0, lo});
      wr(OFF_ENABLE_LOAD, ctrl);
   endtask
endmodule // brs_host_model
`default_nettype wire

// ### testbench/brs_top_test.sv
// Self-checking bench for the reference servo and enable control block
`default_nettype none
module brs_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import brs_pkg::*;
   localparam int unsigned MDIV = 2;
   localparam int unsigned CEIL = 40000;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic [7:0] rexp;
   } brs_row_s;
   brs_row_s rows [6] = '{'{OFF_VOLT_UPPER, 8'h5a, 8'h5a}, '{OFF_VOLT_LOW, 8'h05, 8'h05},
      '{OFF_CUR_TARGET, 8'h33, 8'h33}, '{OFF_SERVO_CFG, 8'hd0, 8'hd0}, '{OFF_ENABLE_LOAD, 8'h00, 8'h00},
      '{4'h0, 8'h77, 8'h00}};
   logic clk, rstn, rd, wr, waitreq, en_pin, bias, reg_en, dis, int_en, step_chk;
   logic [3:0] addr, be;
   logic [31:0] wdata, rdata;
   logic [10:0] vref, prev_v;
   logic [7:0] iref, q;
   int unsigned errors, n_compared, cyc, t0, t1;
   brs_host_model u_host (.clk_i(clk), .waitrequest_i(waitreq), .readdata_i(rdata), .address_o(addr),
      .read_o(rd), .write_o(wr), .writedata_o(wdata), .byteenable_o(be));
   brs_top #(.MASTER_DIV(MDIV)) u_dut (.CLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(waitreq), .ENABLE_PIN_I(en_pin), .BIAS_READY_I(bias),
      .VOLTAGE_REFERENCE_OUTPUT_O(vref), .CURRENT_REFERENCE_CONVERTER_O(iref), .REGULATOR_ENABLE_O(reg_en),
      .OUTPUT_DISCHARGE_PATH_O(dis), .INTERNAL_ENABLE_O(int_en));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wait_chg(output int unsigned t);
      logic [7:0] p;
      int unsigned i;
      p = iref;
      for (i = 0; i < 64 && iref === p; i++) @(posedge clk);
      t = cyc;
   endtask
   task automatic wait_ref(input logic [10:0] ev, input logic [7:0] ei);
      int unsigned i;
      for (i = 0; i < 5000 && !(vref === ev && iref === ei); i++) @(posedge clk);
      chk("vref", {21'h0, ev}, {21'h0, vref});
      chk("iref", {24'h0, ei}, {24'h0, iref});
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      prev_v <= vref;
      // A jump of more than one code would reach the converter as a glitch
      if (step_chk && (vref > prev_v + 11'h1 || prev_v > vref + 11'h1)) begin
         errors++;
         $display("[ERR] vref_step expected %h seen %h", prev_v, vref);
      end
      if (cyc == CEIL) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      rstn = 1'b0;
      en_pin = 1'b0;
      bias = 1'b0;
      step_chk = 1'b0;
      errors = 0;
      n_compared = 0;
      cyc = 0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk("rst_out", 32'h0, {vref, iref, reg_en, dis, int_en});
      foreach (rows[i]) begin
         u_host.wr(rows[i].addr, rows[i].wdata);
         u_host.rd(rows[i].addr, q);
         chk("reg_rd", {24'h0, rows[i].rexp}, {24'h0, q});
      end
      bias <= 1'b1;
      repeat (8) @(posedge clk);
      chk("off_state", {11'h0, 3'b010}, {vref, reg_en, dis, int_en});
      u_host.wr(OFF_CUR_TARGET, 8'hff);
      for (int s = 0; s < 4; s++) begin
         u_host.wr(OFF_SERVO_CFG, 8'(s << 6) | 8'h10);
         wait_chg(t0);
         wait_chg(t0);
         wait_chg(t1);
         chk("tick_period", 32'(MDIV << s), t1 - t0);
      end
      u_host.wr(OFF_ENABLE_LOAD, 8'h01);
      repeat (40) @(posedge clk);
      chk("no_load", {11'h0, 3'b101}, {vref, reg_en, dis, int_en});
      u_host.wr(OFF_SERVO_CFG, 8'h10);
      step_chk <= 1'b1;
      u_host.set_volt(8'h5a, 3'h5, 8'h03);
      u_host.rd(OFF_ENABLE_LOAD, q);
      chk("load_rd", 32'h01, {24'h0, q});
      wait_ref(11'h2d5, 8'hff);
      u_host.set_volt(8'hff, 3'h7, 8'h03);
      repeat (100) @(posedge clk);
      u_host.wr(OFF_CUR_TARGET, 8'h10);
      wait_ref(11'h780, 8'h10);
      u_host.rd(OFF_STATUS, q);
      chk("status", 32'h07, {24'h0, q});
      u_host.wr(OFF_VOLT_UPPER, 8'h10);
      u_host.wr(OFF_ENABLE_LOAD, 8'h01);
      repeat (50) @(posedge clk);
      chk("hold", 32'h780, {21'h0, vref});
      step_chk <= 1'b0;
      u_host.wr(OFF_ENABLE_LOAD, 8'h00);
      repeat (4) @(posedge clk);
      chk("disable", {11'h0, 3'b010}, {vref, reg_en, dis, int_en});
      u_host.wr(OFF_SERVO_CFG, 8'h00);
      repeat (4) @(posedge clk);
      chk("no_dis", 32'h0, {31'h0, dis});
      en_pin <= 1'b1;
      repeat (20) @(posedge clk);
      chk("pin_en", 32'h3, {30'h0, reg_en, int_en});
      chk("soft_start", 32'h1, {31'h0, vref > 11'h0 && vref < 11'h780});
      bias <= 1'b0;
      repeat (4) @(posedge clk);
      chk("bias_low", 32'h0, {31'h0, reg_en});
      complete_run();
   end
endmodule // brs_top_test
`default_nettype wire
